//--- hdl/uafd_pkg.sv
package uafd_pkg;
	// Byte-wide register image of the serial_status_a location
	localparam int STA_RXC_BIT   = 7;
	localparam int STA_TXC_BIT   = 6;
	localparam int STA_TBE_BIT   = 5;
	localparam int STA_FE_BIT    = 4;
	localparam int STA_DOR_BIT   = 3;
	localparam int STA_PE_BIT    = 2;
	localparam int STA_DBL_BIT   = 1;
	localparam int STA_AFM_BIT   = 0;
	// Control byte B
	localparam int CTB_RXEN_BIT  = 4;
	localparam int CTB_TXEN_BIT  = 3;
	localparam int CTB_CSZ2_BIT  = 2;
	localparam int CTB_RX9_BIT   = 1;
	localparam int CTB_TX9_BIT   = 0;
	// Frame-format register and shared location
	localparam int FMT_SEL_BIT   = 7;
	localparam int FMT_STOP_BIT  = 3;
	localparam int FMT_CSZ_LO    = 1;
	localparam int BAUD_HI_W     = 4;
	localparam logic [7:0] FMT_RESET     = 8'h86;
	localparam logic [7:0] BAUD_HI_RESET = 8'h00;
	localparam logic [2:0] CSZ_NINE      = 3'h7;
	// Receive FIFO entry: {fe, dor, pe, ninth, data[7:0]}
	localparam int RXE_W = 12;
	typedef logic [RXE_W-1:0] uafd_rx_entry_t;
endpackage : uafd_pkg

//--- hdl/uafd_fifo_if.sv
`timescale 1ns/1ps
interface uafd_fifo_if;
	import uafd_pkg::*;
	logic           push;
	uafd_rx_entry_t push_data;
	logic           pop;
	logic           flush;
	uafd_rx_entry_t head;
	logic           not_empty;
	logic           full;
	modport store (input push, push_data, pop, flush, output head, not_empty, full);
	modport user  (output push, push_data, pop, flush, input head, not_empty, full);
endinterface : uafd_fifo_if

//--- hdl/uafd_rx_fifo.sv
`timescale 1ns/1ps
module uafd_rx_fifo (
	input  wire logic  i_clk,
	input  wire logic  i_rst_b,
	uafd_fifo_if.store f
);
	import uafd_pkg::*;

	uafd_rx_entry_t tail;
	logic [1:0]     count;
	logic           do_pop;

	assign do_pop      = f.pop && (count != 2'd0);
	assign f.not_empty = (count != 2'd0);
	assign f.full      = (count == 2'd2);

	// Head sits in a register; a pop shifts the tail forward
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			f.head <= '0;
			tail   <= '0;
			count  <= 2'd0;
		end else if (f.flush) begin
			count <= 2'd0;
		end else begin
			unique case (count)
				2'd0: begin
					if (f.push) begin
						f.head <= f.push_data;
						count  <= 2'd1;
					end
				end
				2'd1: begin
					if (f.push && do_pop) begin
						f.head <= f.push_data;
					end else if (f.push) begin
						tail  <= f.push_data;
						count <= 2'd2;
					end else if (do_pop) begin
						count <= 2'd0;
					end
				end
				default: begin
					if (do_pop) begin
						f.head <= tail;
						if (f.push) begin
							tail <= f.push_data;
						end else begin
							count <= 2'd1;
						end
					end
				end
			endcase
		end
	end
endmodule : uafd_rx_fifo

//--- hdl/uafd_top.sv
`timescale 1ns/1ps
module uafd_top (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_sel_data,
	input  wire logic       i_sel_status_a,
	input  wire logic       i_sel_ctrl_b,
	input  wire logic       i_sel_shared,
	input  wire logic       i_io_wr,
	input  wire logic       i_io_rd,
	input  wire logic [7:0] i_io_wdata,
	output logic      [7:0] o_io_rdata,
	input  wire logic       i_rx_frame_valid,
	input  wire logic [8:0] i_rx_data,
	input  wire logic       i_rx_stop1,
	input  wire logic       i_rx_frame_err,
	input  wire logic       i_rx_parity_err,
	input  wire logic       i_rx_overrun,
	input  wire logic       i_tx_shreg_empty,
	input  wire logic       i_tx_frame_done,
	output logic            o_tx_load,
	output logic      [8:0] o_tx_data,
	output logic      [2:0] o_char_size,
	output logic            o_rx_enable,
	output logic            o_tx_enable,
	output logic            o_double_speed,
	output logic      [7:0] o_frame_format,
	output logic      [7:0] o_baud_div_high
);
	import uafd_pkg::*;

	uafd_fifo_if rxq ();

	logic       addr_filter_mode;
	logic       tx_complete_flag;
	logic       tx_buf_empty_flag;
	logic       tx_ninth_bit;
	logic       char_size_hi;
	logic [8:0] tx_data_buffer;
	logic       shared_rd_prev;
	logic       frame_type;
	logic       rx_accept;
	logic [7:0] next_rdata;
	logic [7:0] rx_data_buffer;
	logic       rx_ninth_bit;
	logic       wr_data;
	logic       wr_status;
	logic       wr_ctrl;
	logic       wr_shared;

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Mask of the data bits in use for a character size code
	function automatic logic [7:0] uafd_data_mask(input logic [2:0] csz);
		unique case (csz)
			3'h0:    uafd_data_mask = 8'h1f;
			3'h1:    uafd_data_mask = 8'h3f;
			3'h2:    uafd_data_mask = 8'h7f;
			default: uafd_data_mask = 8'hff;
		endcase
	endfunction : uafd_data_mask

	assign wr_data   = i_io_wr && i_sel_data;
	assign wr_status = i_io_wr && i_sel_status_a;
	assign wr_ctrl   = i_io_wr && i_sel_ctrl_b;
	assign wr_shared = i_io_wr && i_sel_shared;

	assign o_char_size = {char_size_hi, o_frame_format[FMT_CSZ_LO+1:FMT_CSZ_LO]};

	////////////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			addr_filter_mode <= 1'b0;
			o_double_speed   <= 1'b0;
		end else if (wr_status) begin
			addr_filter_mode <= i_io_wdata[STA_AFM_BIT];
			o_double_speed   <= i_io_wdata[STA_DBL_BIT];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rx_enable  <= 1'b0;
			o_tx_enable  <= 1'b0;
			char_size_hi <= 1'b0;
			tx_ninth_bit <= 1'b0;
		end else if (wr_ctrl) begin
			o_rx_enable  <= i_io_wdata[CTB_RXEN_BIT];
			o_tx_enable  <= i_io_wdata[CTB_TXEN_BIT];
			char_size_hi <= i_io_wdata[CTB_CSZ2_BIT];
			tx_ninth_bit <= i_io_wdata[CTB_TX9_BIT];
		end
	end

	// Shared location: written value's top bit picks the target
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_baud_div_high <= BAUD_HI_RESET;
			o_frame_format  <= FMT_RESET;
		end else if (wr_shared) begin
			if (i_io_wdata[FMT_SEL_BIT]) begin
				o_frame_format <= i_io_wdata;
			end else begin
				o_baud_div_high <= {4'h0, i_io_wdata[BAUD_HI_W-1:0]};
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			shared_rd_prev <= 1'b0;
		end else begin
			shared_rd_prev <= i_io_rd && i_sel_shared;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive side

	assign frame_type = (o_char_size == CSZ_NINE) ? i_rx_data[8]
	                                              : i_rx_stop1;
	// Type one is an address; data frames are dropped while filtering
	assign rx_accept  = frame_type || !addr_filter_mode;

	// A full FIFO drops the frame unless a read frees a slot in the same cycle
	assign rxq.push      = i_rx_frame_valid && o_rx_enable && rx_accept
	                       && (!rxq.full || rxq.pop);
	assign rxq.push_data = {i_rx_frame_err, i_rx_overrun, i_rx_parity_err,
	                        i_rx_data[8], i_rx_data[7:0]};
	assign rxq.pop       = i_io_rd && i_sel_data;
	assign rxq.flush     = !o_rx_enable;

	uafd_rx_fifo u_rx_fifo (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.f       (rxq.store)
	);

	assign rx_data_buffer = rxq.head[7:0] & uafd_data_mask(o_char_size);
	assign rx_ninth_bit   = rxq.not_empty && rxq.head[8];

	////////////////////////////////////////////////////////////////////////////
	// Transmit side, independent of the filter mode

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_data_buffer    <= 9'h000;
			tx_buf_empty_flag <= 1'b1;
		end else if (wr_data && tx_buf_empty_flag) begin
			tx_data_buffer    <= {tx_ninth_bit, i_io_wdata & uafd_data_mask(o_char_size)};
			tx_buf_empty_flag <= 1'b0;
		end else if (o_tx_load) begin
			tx_buf_empty_flag <= 1'b1;
		end
	end

	assign o_tx_load = o_tx_enable && !tx_buf_empty_flag && i_tx_shreg_empty;
	assign o_tx_data = tx_data_buffer;

	// Completion set wins over a software clear in the same cycle
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tx_complete_flag <= 1'b0;
		end else if (i_tx_frame_done && tx_buf_empty_flag) begin
			tx_complete_flag <= 1'b1;
		end else if (wr_status && i_io_wdata[STA_TXC_BIT]) begin
			tx_complete_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data, registered one cycle after the read strobe

	always_comb begin
		next_rdata = 8'h00;
		if (i_sel_data) begin
			next_rdata = rx_data_buffer;
		end else if (i_sel_status_a) begin
			next_rdata[STA_RXC_BIT] = rxq.not_empty;
			next_rdata[STA_TXC_BIT] = tx_complete_flag;
			next_rdata[STA_TBE_BIT] = tx_buf_empty_flag;
			next_rdata[STA_FE_BIT]  = rxq.not_empty && rxq.head[11];
			next_rdata[STA_DOR_BIT] = rxq.not_empty && rxq.head[10];
			next_rdata[STA_PE_BIT]  = rxq.not_empty && rxq.head[9];
			next_rdata[STA_DBL_BIT] = o_double_speed;
			next_rdata[STA_AFM_BIT] = addr_filter_mode;
		end else if (i_sel_ctrl_b) begin
			next_rdata[CTB_RXEN_BIT] = o_rx_enable;
			next_rdata[CTB_TXEN_BIT] = o_tx_enable;
			next_rdata[CTB_CSZ2_BIT] = char_size_hi;
			next_rdata[CTB_RX9_BIT]  = rx_ninth_bit;
			next_rdata[CTB_TX9_BIT]  = tx_ninth_bit;
		end else if (i_sel_shared) begin
			if (shared_rd_prev) begin
				next_rdata = o_frame_format | 8'h80;
			end else begin
				next_rdata = o_baud_div_high;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_io_rdata <= 8'h00;
		end else if (i_io_rd) begin
			o_io_rdata <= next_rdata;
		end
	end
endmodule : uafd_top

//--- dv/uafd_asserts.sv
`timescale 1ns/1ps
module uafd_asserts (
	input wire logic       i_clk,
	input wire logic       i_rst_b,
	input wire logic       i_sel_data,
	input wire logic       i_sel_shared,
	input wire logic       i_io_wr,
	input wire logic       i_io_rd,
	input wire logic [7:0] i_io_wdata,
	input wire logic [7:0] o_io_rdata,
	input wire logic       i_tx_shreg_empty,
	input wire logic       o_tx_load,
	input wire logic       o_tx_enable,
	input wire logic [2:0] o_char_size,
	input wire logic [7:0] o_frame_format,
	input wire logic [7:0] o_baud_div_high
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	wire rs = i_io_rd && i_sel_shared;
	wire ws = i_io_wr && i_sel_shared;
	sequence s_one_rd; !rs ##1 rs; endsequence
	sequence s_two_rd; rs ##1 rs; endsequence
	property p_load; o_tx_load |-> o_tx_enable && i_tx_shreg_empty; endproperty
	a_load: assert property (p_load) else $error("load not allowed");
	property p_load_one; o_tx_load |=> !o_tx_load; endproperty
	a_load_one: assert property (p_load_one) else $error("load repeated");
	property p_fmt_wr;
		ws && i_io_wdata[7] |=> o_frame_format == $past(i_io_wdata) && $stable(o_baud_div_high);
	endproperty
	a_fmt_wr: assert property (p_fmt_wr) else $error("format write");
	property p_baud_wr;
		ws && !i_io_wdata[7] |=> o_baud_div_high == {4'h0, $past(i_io_wdata[3:0])};
	endproperty
	a_baud_wr: assert property (p_baud_wr) else $error("baud write");
	property p_rd_baud; s_one_rd |=> o_io_rdata == $past(o_baud_div_high); endproperty
	a_rd_baud: assert property (p_rd_baud) else $error("baud read");
	property p_rd_fmt; s_two_rd |=> o_io_rdata == ($past(o_frame_format) | 8'h80); endproperty
	a_rd_fmt: assert property (p_rd_fmt) else $error("format read");
	property p_rd_hold; !i_io_rd |=> $stable(o_io_rdata); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_mask; i_io_rd && i_sel_data && o_char_size == 3'h0 |=> o_io_rdata[7:5] == 3'h0;
	endproperty
	a_mask: assert property (p_mask) else $error("upper bits set");
endmodule : uafd_asserts
bind uafd_top uafd_asserts u_chk (.*);

//--- dv/uafd_far_end.sv
`timescale 1ns/1ps
module uafd_far_end (
	input  wire logic       i_clk,
	input  wire logic       i_load,
	input  wire logic [8:0] i_data,
	output logic            o_valid,
	output logic      [8:0] o_rx,
	output logic            o_stop1,
	output logic            o_empty,
	output logic            o_done,
	output logic      [8:0] o_last
);
	logic [3:0] cnt;
	initial begin
		o_valid = 1'b0;
		o_rx = 9'h000;
		o_stop1 = 1'b1;
		o_empty = 1'b1;
		o_done = 1'b0;
		o_last = 9'h1ff;
		cnt = 4'h0;
	end
	// Shifter stays busy four cycles per frame
	always @(posedge i_clk) begin
		o_done <= 1'b0;
		if (i_load) begin
			o_last <= i_data;
			o_empty <= 1'b0;
			cnt <= 4'h4;
		end else if (cnt == 4'h1) begin
			o_empty <= 1'b1;
			o_done <= 1'b1;
			cnt <= 4'h0;
		end else if (cnt != 4'h0) begin
			cnt <= cnt - 4'h1;
		end
	end
	task automatic send(input logic [8:0] d, input logic s);
		@(negedge i_clk);
		o_valid = 1'b1;
		o_rx = d;
		o_stop1 = s;
		@(negedge i_clk);
		o_valid = 1'b0;
		o_rx = ~d;
		o_stop1 = ~s;
	endtask : send
endmodule : uafd_far_end

//--- dv/uafd_top_tb.sv
`timescale 1ns/1ps
module uafd_top_tb;
	logic       clk, rst_b, io_wr, io_rd, load, emp, done, rv, st1;
	logic [7:0] wdata, rdata;
	logic [8:0] txd, rxd;
	logic [3:0] sel;
	logic [2:0] rxe, csz;
	logic       rxen, txen, dbl;
	logic [7:0] fmt, bdh;
	int         err_total, checked;
	uafd_top dut (
		.i_clk(clk), .i_rst_b(rst_b), .i_sel_data(sel[0]), .i_sel_status_a(sel[1]),
		.i_sel_ctrl_b(sel[2]), .i_sel_shared(sel[3]), .i_io_wr(io_wr), .i_io_rd(io_rd),
		.i_io_wdata(wdata), .o_io_rdata(rdata), .i_rx_frame_valid(rv), .i_rx_data(rxd),
		.i_rx_stop1(st1), .i_rx_frame_err(rxe[2]), .i_rx_parity_err(rxe[0]),
		.i_rx_overrun(rxe[1]), .i_tx_shreg_empty(emp), .i_tx_frame_done(done),
		.o_tx_load(load), .o_tx_data(txd), .o_char_size(csz), .o_rx_enable(rxen),
		.o_tx_enable(txen), .o_double_speed(dbl), .o_frame_format(fmt),
		.o_baud_div_high(bdh)
	);
	uafd_far_end far (
		.i_clk(clk), .i_load(load), .i_data(txd), .o_valid(rv), .o_rx(rxd),
		.o_stop1(st1), .o_empty(emp), .o_done(done), .o_last()
	);
	task automatic chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input int s, input logic [7:0] d);
		@(negedge clk);
		sel = 4'h1 << s;
		io_wr = 1'b1;
		wdata = d;
		@(negedge clk);
		sel = 4'h0;
		io_wr = 1'b0;
	endtask : wr
	// Strobe held n cycles gives n back-to-back reads
	task automatic rd(input int s, input int n, input logic [7:0] m, input logic [7:0] e,
		input string nm);
		logic [7:0] q;
		@(negedge clk);
		sel = 4'h1 << s;
		io_rd = 1'b1;
		repeat (n) @(negedge clk);
		q = rdata & m;
		sel = 4'h0;
		io_rd = 1'b0;
		chk(nm, {1'b0, q}, {1'b0, e});
	endtask : rd
	task automatic tally_and_finish;
		$display("checked %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#5000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		{err_total, checked} = 0;
		{rst_b, io_wr, io_rd, sel, wdata, rxe} = 0;
		repeat (3) @(negedge clk);
		rst_b = 1'b1;
		rd(3, 1, 8'hff, 8'h00, "baud");
		rd(3, 2, 8'hff, 8'h86, "fmt");
		wr(3, 8'h05);
		wr(3, 8'h8e);
		chk("baud_out", {1'b0, bdh}, 9'h005);
		chk("fmt_out", {1'b0, fmt}, 9'h08e);
		chk("size", {6'h00, csz}, 9'h003);
		rd(3, 1, 8'hff, 8'h05, "baud");
		rd(3, 2, 8'hff, 8'h8e, "fmt");
		wr(2, 8'h18);
		chk("enables", {7'h00, rxen, txen}, 9'h003);
		wr(1, 8'h01);
		far.send(9'h0a5, 1'b0);
		rd(1, 1, 8'h80, 8'h00, "rxc");
		far.send(9'h05a, 1'b1);
		rd(1, 1, 8'h80, 8'h80, "rxc");
		rd(0, 1, 8'hff, 8'h5a, "rx");
		wr(1, 8'h00);
		rxe = 3'h5;
		far.send(9'h011, 1'b0);
		rxe = 3'h0;
		far.send(9'h022, 1'b0);
		far.send(9'h033, 1'b0);
		rd(1, 1, 8'h1c, 8'h14, "err");
		rd(0, 1, 8'hff, 8'h11, "rx");
		rd(1, 1, 8'h1c, 8'h00, "err");
		rd(0, 1, 8'hff, 8'h22, "rx");
		rd(1, 1, 8'h80, 8'h00, "rxc");
		wr(2, 8'h1c);
		chk("size", {6'h00, csz}, 9'h007);
		wr(1, 8'h01);
		far.send(9'h13c, 1'b0);
		far.send(9'h044, 1'b1);
		rd(2, 1, 8'h02, 8'h02, "ninth");
		rd(0, 1, 8'hff, 8'h3c, "rx");
		rd(1, 1, 8'h80, 8'h00, "rxc");
		wr(3, 8'h88);
		wr(2, 8'h10);
		chk("size", {6'h00, csz}, 9'h000);
		far.send(9'h0ff, 1'b1);
		rd(0, 1, 8'hff, 8'h1f, "rx");
		wr(3, 8'h84);
		far.send(9'h0ff, 1'b1);
		rd(0, 1, 8'hff, 8'h7f, "rx");
		wr(3, 8'h82);
		far.send(9'h0ff, 1'b1);
		rd(0, 1, 8'hff, 8'h3f, "rx");
		wr(3, 8'h88);
		wr(0, 8'hea);
		rd(1, 1, 8'h20, 8'h00, "tbe");
		wr(0, 8'h55);
		wr(2, 8'h18);
		repeat (8) @(negedge clk);
		chk("tx", far.o_last, 9'h00a);
		rd(1, 1, 8'h60, 8'h60, "txc");
		wr(1, 8'h43);
		chk("dbl", {8'h00, dbl}, 9'h001);
		rd(1, 1, 8'h43, 8'h03, "txc");
		tally_and_finish();
	end
endmodule : uafd_top_tb
